/* hw/ska_pkg.sv */
// Purpose: Constants and types for the shaped keying amplitude path
// Assumes: Registers reached through a byte-wide buffered write/read port
// Notes: Buffer contents move to the active bank on an update strobe
// Function
// - Keying enable low bypasses multipliers; both paths at full scale.
// - Internal ramp select high uses linear ramp; low uses shape registers.
// - Separate 12-bit I and Q scale registers at offsets 21 to 24 hex.
// - Programmable 8-bit ramp-rate down-counter emits a pulse at zero.
// - Each ramp pulse steps a 12-bit amplitude counter feeding the multiplier.
// - Zero scales to zero, all ones to 4095/4096, proportional between.
// - Ramp-rate count below three stalls counter; scale holds constant.
// - Pulse interval is N plus one system clock periods.
// - Full ramp from zero to full scale takes 4095 pulses.
// - Keying pin high ramps up and holds; low ramps down to zero.
// - Sine drives the Q path, cosine drives the I path.
// - Converter power-down bit high powers down both DACs.
// - Q source bit high feeds Q DAC from user two's-complement data.
// - Auxiliary Q data written through the port into the Q DAC register.
// - Q DAC power-down bit powers down Q DAC independently.
// - Inverse sinc applies to both DACs except Q in auxiliary mode.
// - Inverse sinc engaged after reset; bypassed when bypass bit high.
// - Clock multiplier supports 4 to 20 via a five-bit field.
// - PLL bypass selects reference clock, else multiplier output.
// - Multiplier field is plain unsigned binary, 4 through 20.
// - Writes land in a buffer; update strobe moves them to active bank.
package ska_pkg;
  localparam int SKA_AW = 6;
  localparam int SKA_SW = 12;
  localparam int SKA_RW = 8;
  localparam logic [SKA_AW-1:0] SKA_ADDR_PD = 6'h1d;
  localparam logic [SKA_AW-1:0] SKA_ADDR_CLK = 6'h1e;
  localparam logic [SKA_AW-1:0] SKA_ADDR_SRC = 6'h1f;
  localparam logic [SKA_AW-1:0] SKA_ADDR_CTL = 6'h20;
  localparam logic [SKA_AW-1:0] SKA_ADDR_IHI = 6'h21;
  localparam logic [SKA_AW-1:0] SKA_ADDR_ILO = 6'h22;
  localparam logic [SKA_AW-1:0] SKA_ADDR_QHI = 6'h23;
  localparam logic [SKA_AW-1:0] SKA_ADDR_QLO = 6'h24;
  localparam logic [SKA_AW-1:0] SKA_ADDR_RATE = 6'h25;
  localparam logic [SKA_AW-1:0] SKA_ADDR_AUXHI = 6'h26;
  localparam logic [SKA_AW-1:0] SKA_ADDR_AUXLO = 6'h27;
  localparam logic [SKA_AW-1:0] SKA_ADDR_AMPLO = 6'h28;
  localparam logic [SKA_AW-1:0] SKA_ADDR_AMPHI = 6'h29;
  localparam int SKA_BIT_QPD = 2;
  localparam int SKA_BIT_BOTHPD = 4;
  localparam int SKA_BIT_PLLRANGE = 6;
  localparam int SKA_BIT_PLLBYP = 5;
  localparam int SKA_BIT_QSRC = 0;
  localparam int SKA_BIT_SINCBYP = 6;
  localparam int SKA_BIT_KEYEN = 5;
  localparam int SKA_BIT_INTRAMP = 4;
  localparam logic [4:0] SKA_MULT_MIN = 5'h04;
  localparam logic [4:0] SKA_MULT_MAX = 5'h14;
  localparam logic [4:0] SKA_MULT_RST = 5'h04;
  localparam logic [SKA_RW-1:0] SKA_RATE_MIN = 8'h03;
  localparam logic [SKA_SW-1:0] SKA_FULL = 12'hfff;
  localparam logic [SKA_SW-1:0] SKA_ZERO = 12'h000;

  typedef struct packed {
    logic both_converters_powerdown;
    logic q_powerdown;
    logic [4:0] mult_value;
    logic pll_range;
    logic pll_bypass;
    logic quad_dac_source_select;
    logic sinc_bypass;
    logic keying_enable;
    logic internal_ramp_select;
    logic [SKA_SW-1:0] i_amplitude_scale;
    logic [SKA_SW-1:0] q_amplitude_scale;
    logic [SKA_RW-1:0] ramp_rate;
    logic [SKA_SW-1:0] q_dac_aux_value;
  } ska_bank_t;

  typedef struct packed {
    logic [SKA_SW-1:0] i_data;
    logic [SKA_SW-1:0] q_data;
    logic i_powerdown;
    logic q_powerdown;
    logic i_sinc_on;
    logic q_sinc_on;
  } ska_dac_t;
endpackage : ska_pkg

/* hw/ska_scale.sv */
// Purpose: Scales a signed sample by a 12-bit fraction of 4096
// Assumes: Sample is two's complement
// Notes: Registered output
`timescale 1ns/1ps
module ska_scale #(
  parameter int W = 12
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [W-1:0] sample,
  input wire logic [W-1:0] factor,
  input wire logic bypass,
  output logic [W-1:0] result
);
  logic signed [2*W:0] prod;
  assign prod = $signed(sample) * $signed({1'b0, factor});
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result <= '0;
    end else if (clk_en) begin
      if (bypass) begin
        result <= sample;
      end else begin
        result <= prod[2*W-1:W];
      end
    end
  end
endmodule : ska_scale

/* hw/ska_top.sv */
// Purpose: Shaped keying amplitude path, Q DAC source and clock config
// Assumes: Register port and update strobe are synchronous to core_clk
// Notes: Keying pin is asynchronous and is synchronised
`timescale 1ns/1ps
module ska_top (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [ska_pkg::SKA_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic update,
  input wire logic keying_pin,
  input wire logic [ska_pkg::SKA_SW-1:0] dds_sine,
  input wire logic [ska_pkg::SKA_SW-1:0] dds_cosine,
  output ska_pkg::ska_dac_t dac_out,
  output logic [4:0] mult_value,
  output logic pll_range,
  output logic sysclk_from_ref,
  output logic [ska_pkg::SKA_SW-1:0] amp_count
);
  import ska_pkg::*;

  ska_bank_t buf_r;
  ska_bank_t act_r;
  logic key_s1_r;
  logic key_s2_r;
  logic [SKA_RW-1:0] rate_cnt_r;
  logic ramp_pulse;
  logic [SKA_SW-1:0] amp_r;
  logic [SKA_SW-1:0] i_fac;
  logic [SKA_SW-1:0] q_fac;
  logic [SKA_SW-1:0] i_scaled;
  logic [SKA_SW-1:0] q_scaled;
  logic mult_bypass;
  logic [4:0] mult_clip;
  logic [7:0] rd_nxt;

  // Buffer writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      buf_r <= '0;
      buf_r.mult_value <= SKA_MULT_RST;
    end else if (clk_en && wr_en) begin
      case (addr)
        SKA_ADDR_PD: begin
          buf_r.both_converters_powerdown <= wdata[SKA_BIT_BOTHPD];
          buf_r.q_powerdown <= wdata[SKA_BIT_QPD];
        end
        SKA_ADDR_CLK: begin
          buf_r.pll_range <= wdata[SKA_BIT_PLLRANGE];
          buf_r.pll_bypass <= wdata[SKA_BIT_PLLBYP];
          buf_r.mult_value <= wdata[4:0];
        end
        SKA_ADDR_SRC: buf_r.quad_dac_source_select <= wdata[SKA_BIT_QSRC];
        SKA_ADDR_CTL: begin
          buf_r.sinc_bypass <= wdata[SKA_BIT_SINCBYP];
          buf_r.keying_enable <= wdata[SKA_BIT_KEYEN];
          buf_r.internal_ramp_select <= wdata[SKA_BIT_INTRAMP];
        end
        SKA_ADDR_IHI: buf_r.i_amplitude_scale[SKA_SW-1:8] <= wdata[3:0];
        SKA_ADDR_ILO: buf_r.i_amplitude_scale[7:0] <= wdata;
        SKA_ADDR_QHI: buf_r.q_amplitude_scale[SKA_SW-1:8] <= wdata[3:0];
        SKA_ADDR_QLO: buf_r.q_amplitude_scale[7:0] <= wdata;
        SKA_ADDR_RATE: buf_r.ramp_rate <= wdata;
        SKA_ADDR_AUXHI: buf_r.q_dac_aux_value[SKA_SW-1:8] <= wdata[3:0];
        SKA_ADDR_AUXLO: buf_r.q_dac_aux_value[7:0] <= wdata;
        default: ;
      endcase
    end
  end

  // Update moves buffer into active bank
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      act_r <= '0;
      act_r.mult_value <= SKA_MULT_RST;
    end else if (clk_en && update) begin
      act_r <= buf_r;
    end
  end

  // Readback of buffer and amplitude counter
  always_comb begin
    rd_nxt = 8'h00;
    case (addr)
      SKA_ADDR_PD: begin
        rd_nxt[SKA_BIT_BOTHPD] = buf_r.both_converters_powerdown;
        rd_nxt[SKA_BIT_QPD] = buf_r.q_powerdown;
      end
      SKA_ADDR_CLK: begin
        rd_nxt[SKA_BIT_PLLRANGE] = buf_r.pll_range;
        rd_nxt[SKA_BIT_PLLBYP] = buf_r.pll_bypass;
        rd_nxt[4:0] = buf_r.mult_value;
      end
      SKA_ADDR_SRC: rd_nxt[SKA_BIT_QSRC] = buf_r.quad_dac_source_select;
      SKA_ADDR_CTL: begin
        rd_nxt[SKA_BIT_SINCBYP] = buf_r.sinc_bypass;
        rd_nxt[SKA_BIT_KEYEN] = buf_r.keying_enable;
        rd_nxt[SKA_BIT_INTRAMP] = buf_r.internal_ramp_select;
      end
      SKA_ADDR_IHI: rd_nxt[3:0] = buf_r.i_amplitude_scale[SKA_SW-1:8];
      SKA_ADDR_ILO: rd_nxt = buf_r.i_amplitude_scale[7:0];
      SKA_ADDR_QHI: rd_nxt[3:0] = buf_r.q_amplitude_scale[SKA_SW-1:8];
      SKA_ADDR_QLO: rd_nxt = buf_r.q_amplitude_scale[7:0];
      SKA_ADDR_RATE: rd_nxt = buf_r.ramp_rate;
      SKA_ADDR_AUXHI: rd_nxt[3:0] = buf_r.q_dac_aux_value[SKA_SW-1:8];
      SKA_ADDR_AUXLO: rd_nxt = buf_r.q_dac_aux_value[7:0];
      SKA_ADDR_AMPLO: rd_nxt = amp_r[7:0];
      SKA_ADDR_AMPHI: rd_nxt[3:0] = amp_r[SKA_SW-1:8];
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (clk_en && rd_en) begin
      rdata <= rd_nxt;
    end
  end

  // Keying pin synchroniser
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      key_s1_r <= 1'b0;
      key_s2_r <= 1'b0;
    end else if (clk_en) begin
      key_s1_r <= keying_pin;
      key_s2_r <= key_s1_r;
    end
  end

  // Ramp-rate down-counter
  assign ramp_pulse = (act_r.ramp_rate >= SKA_RATE_MIN) && (rate_cnt_r == 8'h00);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rate_cnt_r <= 8'h00;
    end else if (clk_en) begin
      if (act_r.ramp_rate < SKA_RATE_MIN) begin
        rate_cnt_r <= rate_cnt_r;
      end else if (rate_cnt_r == 8'h00) begin
        rate_cnt_r <= act_r.ramp_rate;
      end else begin
        rate_cnt_r <= rate_cnt_r - 8'h01;
      end
    end
  end

  // Amplitude up/down counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      amp_r <= SKA_ZERO;
    end else if (clk_en && ramp_pulse) begin
      if (key_s2_r && amp_r != SKA_FULL) begin
        amp_r <= amp_r + 12'h001;
      end else if (!key_s2_r && amp_r != SKA_ZERO) begin
        amp_r <= amp_r - 12'h001;
      end
    end
  end

  // Scale source selection
  assign mult_bypass = !act_r.keying_enable;
  assign i_fac = act_r.internal_ramp_select ? amp_r : act_r.i_amplitude_scale;
  assign q_fac = act_r.internal_ramp_select ? amp_r : act_r.q_amplitude_scale;

  ska_scale #(.W(SKA_SW)) u_scale_i (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .sample(dds_cosine),
    .factor(i_fac),
    .bypass(mult_bypass),
    .result(i_scaled)
  );

  ska_scale #(.W(SKA_SW)) u_scale_q (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .sample(dds_sine),
    .factor(q_fac),
    .bypass(mult_bypass),
    .result(q_scaled)
  );

  // DAC outputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dac_out <= '0;
    end else if (clk_en) begin
      dac_out.i_data <= i_scaled;
      dac_out.q_data <= act_r.quad_dac_source_select ? act_r.q_dac_aux_value : q_scaled;
      dac_out.i_powerdown <= act_r.both_converters_powerdown;
      dac_out.q_powerdown <= act_r.both_converters_powerdown | act_r.q_powerdown;
      dac_out.i_sinc_on <= !act_r.sinc_bypass;
      dac_out.q_sinc_on <= !act_r.sinc_bypass && !act_r.quad_dac_source_select;
    end
  end

  // Clock multiplier configuration
  always_comb begin
    if (act_r.mult_value < SKA_MULT_MIN) begin
      mult_clip = SKA_MULT_MIN;
    end else if (act_r.mult_value > SKA_MULT_MAX) begin
      mult_clip = SKA_MULT_MAX;
    end else begin
      mult_clip = act_r.mult_value;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mult_value <= SKA_MULT_RST;
      pll_range <= 1'b0;
      sysclk_from_ref <= 1'b0;
      amp_count <= SKA_ZERO;
    end else if (clk_en) begin
      mult_value <= mult_clip;
      pll_range <= act_r.pll_range;
      sysclk_from_ref <= act_r.pll_bypass;
      amp_count <= amp_r;
    end
  end
endmodule : ska_top

/* sim/ska_properties.sv */
// Purpose: Port checker for ska_top
// Assumes: One clock, rstn async active low
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module ska_props (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic rd_en,
  input wire logic update,
  input wire logic [7:0] rdata,
  input wire ska_pkg::ska_dac_t dac_out,
  input wire logic [4:0] mult_value,
  input wire logic [ska_pkg::SKA_SW-1:0] amp_count
);
  import ska_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_hold3;
    $stable(amp_count)[*3];
  endsequence
  chk_amp_unit_step:
    assert property ($changed(amp_count) |-> amp_count == $past(amp_count) + 12'h001
      || amp_count == $past(amp_count) - 12'h001) else $error("amp step not one");
  chk_step_gap:
    assert property ($changed(amp_count) |=> s_hold3) else $error("amp steps too close");
  chk_no_wrap_hi:
    assert property (amp_count == SKA_FULL |=> amp_count != SKA_ZERO) else $error("wrap up");
  chk_no_wrap_lo:
    assert property (amp_count == SKA_ZERO |=> amp_count != SKA_FULL) else $error("wrap down");
  chk_freeze_state:
    assert property (!clk_en |=> $stable(amp_count) && $stable(dac_out))
      else $error("state moved while frozen");
  chk_rdata_stands:
    assert property ($changed(rdata) |-> $past(rd_en)) else $error("rdata changed alone");
  chk_mult_range:
    assert property (mult_value >= SKA_MULT_MIN && mult_value <= SKA_MULT_MAX)
      else $error("multiplier out of range");
  chk_mult_update:
    assert property ($changed(mult_value) |-> $past(update) || $past(update, 2))
      else $error("multiplier changed without update");
  chk_pd_pair:
    assert property (dac_out.i_powerdown |-> dac_out.q_powerdown) else $error("pd mismatch");
endmodule : ska_props

/* sim/ska_host.sv */
// Purpose: Host model driving the register port and keying pin
// Assumes: Drives just after the core_clk rising edge
// Notes: Released write data shows the inverse of the last byte
`timescale 1ns/1ps
module ska_host (
  input wire logic core_clk,
  input wire logic [7:0] rdata,
  output logic wr_en = 1'b0,
  output logic rd_en = 1'b0,
  output logic [ska_pkg::SKA_AW-1:0] addr = 6'h00,
  output logic [7:0] wdata = 8'h00,
  output logic update = 1'b0,
  output logic keying_pin = 1'b0
);
  import ska_pkg::*;
  task automatic wr(input logic [SKA_AW-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask : wr
  task automatic wr12(input logic [SKA_AW-1:0] a, input logic [11:0] v);
    wr(a, {4'h0, v[11:8]});
    wr(a + 6'h01, v[7:0]);
  endtask : wr12
  task automatic rd(input logic [SKA_AW-1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : rd
  task automatic upd;
    @(posedge core_clk);
    update <= 1'b1;
    @(posedge core_clk);
    update <= 1'b0;
  endtask : upd
  task automatic key(input logic v);
    @(posedge core_clk);
    keying_pin <= v;
  endtask : key
endmodule : ska_host

/* sim/ska_top_tb.sv */
// Purpose: Self-checking bench for ska_top
// Assumes: 50 MHz core_clk, fixed seed
// Notes: Samples outputs on the falling edge
`timescale 1ns/1ps
module ska_top_tb;
  import ska_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic wr_en, rd_en, update, keying_pin, pll_range, sysclk_from_ref;
  logic [SKA_AW-1:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [11:0] sine = 12'h000, cosine = 12'h000, amp_count, f;
  logic [4:0] mult_value, pm;
  ska_dac_t dac_out;
  int error_cnt = 0, checks = 0, seed = 64688, n, k, c, t;
  always #10 core_clk = ~core_clk;
  ska_top dut (.core_clk, .rstn, .clk_en, .wr_en, .rd_en, .addr, .wdata, .rdata, .update,
    .keying_pin, .dds_sine(sine), .dds_cosine(cosine), .dac_out, .mult_value, .pll_range,
    .sysclk_from_ref, .amp_count);
  ska_host host (.core_clk, .rdata, .wr_en, .rd_en, .addr, .wdata, .update, .keying_pin);
  task automatic test_done;
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wch(output int cn);
    logic [11:0] p;
    p = amp_count;
    cn = 0;
    while (amp_count === p) begin
      @(negedge core_clk);
      cn++;
      if (cn > 300) begin
        chk(cn, 0, "amp stuck");
        test_done();
      end
    end
  endtask : wch
  function automatic logic [11:0] scl(input logic [11:0] s, input logic [11:0] g);
    logic signed [24:0] pr;
    pr = $signed(s) * $signed({1'b0, g});
    return pr[23:12];
  endfunction : scl
  task automatic upw(input int w);
    host.upd();
    repeat (w) @(negedge core_clk);
  endtask : upw
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    sine <= 12'($random(seed));
    cosine <= 12'($random(seed));
    repeat (4) @(negedge core_clk);
    chk(mult_value, 5'h04, "mult rst");
    chk({dac_out.i_sinc_on, dac_out.q_sinc_on}, 2'h3, "sinc rst");
    chk({dac_out.i_data, dac_out.q_data}, {cosine, sine}, "bypass");
    host.rd(6'h3f, rv);
    chk(rv, 8'h00, "unmapped");
    host.wr(SKA_ADDR_CTL, 8'h20);
    for (k = 0; k < 3; k++) begin
      f = (k == 0) ? 12'h000 : (k == 1) ? 12'hfff : 12'($random(seed));
      host.wr12(SKA_ADDR_IHI, f);
      host.wr12(SKA_ADDR_QHI, ~f);
      upw(5);
      chk({dac_out.i_data, dac_out.q_data}, {scl(cosine, f), scl(sine, ~f)}, "shape");
    end
    host.rd(SKA_ADDR_QHI, rv);
    chk(rv, {4'h0, ~f[11:8]}, "q scale rd");
    pm = 5'h04;
    for (k = 4; k <= 20; k++) begin
      host.wr(SKA_ADDR_CLK, {1'b0, k[0], ~k[0], k[4:0]});
      chk(mult_value, pm, "pre upd");
      upw(3);
      pm = k[4:0];
      chk({mult_value, pll_range, sysclk_from_ref}, {pm, k[0], ~k[0]}, "clk");
    end
    host.wr(SKA_ADDR_CLK, 8'h02);
    upw(3);
    chk(mult_value, 5'h04, "clip");
    host.wr(SKA_ADDR_PD, 8'h04);
    upw(3);
    chk({dac_out.i_powerdown, dac_out.q_powerdown}, 2'h1, "q pd");
    host.wr(SKA_ADDR_PD, 8'h10);
    upw(3);
    chk({dac_out.i_powerdown, dac_out.q_powerdown}, 2'h3, "both pd");
    f = 12'($random(seed));
    host.wr(SKA_ADDR_PD, 8'h00);
    host.wr12(SKA_ADDR_AUXHI, f);
    host.wr(SKA_ADDR_SRC, 8'h01);
    upw(5);
    chk({dac_out.q_data, dac_out.q_sinc_on, dac_out.i_sinc_on}, {f, 2'h1}, "aux");
    host.rd(SKA_ADDR_AUXLO, rv);
    chk(rv, f[7:0], "aux rd");
    host.wr(SKA_ADDR_CTL, 8'h40);
    upw(3);
    chk({dac_out.i_sinc_on, dac_out.q_sinc_on}, 2'h0, "sinc byp");
    n = 3 + ($unsigned($random(seed)) % 13);
    host.wr(SKA_ADDR_SRC, 8'h00);
    host.wr(SKA_ADDR_CTL, 8'h30);
    host.wr(SKA_ADDR_RATE, 8'(n));
    upw(1);
    host.key(1'b1);
    wch(c);
    wch(c);
    chk(c, n + 1, "interval");
    chk(amp_count, 12'h002, "ramp up");
    host.key(1'b0);
    for (k = 0; k < 5 && amp_count !== 12'h000; k++) wch(c);
    host.wr(SKA_ADDR_RATE, 8'h03);
    upw(1);
    host.key(1'b1);
    wch(c);
    t = 0;
    for (k = 0; k < 5000 && amp_count !== 12'hfff; k++) begin
      wch(c);
      t += c;
    end
    chk(t, 4094 * 4, "full ramp");
    repeat (20) @(negedge core_clk);
    chk(amp_count, 12'hfff, "sat");
    host.key(1'b0);
    wch(c);
    chk(amp_count, 12'hffe, "ramp down");
    @(posedge core_clk);
    clk_en <= 1'b0;
    repeat (12) @(posedge core_clk);
    clk_en <= 1'b1;
    host.wr(SKA_ADDR_RATE, 8'h02);
    upw(10);
    f = amp_count;
    repeat (40) @(negedge core_clk);
    chk(amp_count, f, "stall");
    chk({dac_out.i_data, dac_out.q_data}, {scl(cosine, f), scl(sine, f)}, "ramp scale");
    host.rd(SKA_ADDR_RATE, rv);
    chk(rv, 8'h02, "rate rd");
    test_done();
  end
endmodule : ska_top_tb
bind ska_top ska_props chk_i (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
  .rd_en(rd_en), .update(update), .rdata(rdata), .dac_out(dac_out),
  .mult_value(mult_value), .amp_count(amp_count));
